// file: agf_pkg.sv
// constants for the gain and output format register bank
// assumes a wishbone classic slave with 32-bit data and word-aligned registers
//
// Behaviour
// - hardware or software reset clears every bit of registers 0b, 0c and 0d to zero
// - register 0c bits 2..0 hold test pattern bits 13..11
// - fine gain code 000..110 means 0 dB up to 6 dB in 1 dB steps
// - 0d bit0 wire count, bit1 ddr/sdr in 2-wire, bit2 14x/16x serialization
// - with sdr clock, 0d bit4 picks falling (0) or rising (1) capture edge
// - 0d bit5 enables the 3.5 dB coarse gain
// - 0d bit6 selects msb first (0) or lsb first (1)
// - in 2-wire mode, 0d bit7 selects byte-wise (0) or bit-wise (1) split
// - 0d bit10 set makes the register settings override the control pins
// - register 0b holds the lower eleven bits of the custom test pattern
package agf_pkg;

    // register indices; byte address is four times the index
    localparam logic [4:0] AGF_IDX_SOFT_RESET = 5'h00;
    localparam logic [4:0] AGF_IDX_PATTERN_LOW = 5'h0b;
    localparam logic [4:0] AGF_IDX_FINE_GAIN = 5'h0c;
    localparam logic [4:0] AGF_IDX_FORMAT = 5'h0d;
    localparam logic [4:0] AGF_IDX_STATUS = 5'h1e;

    localparam int AGF_REG_W = 11;
    localparam int AGF_PAT_W = 14;

    // writable bits of each register
    localparam logic [10:0] AGF_MASK_PATTERN_LOW = 11'h7ff;
    localparam logic [10:0] AGF_MASK_FINE_GAIN = 11'h707;
    localparam logic [10:0] AGF_MASK_FORMAT = 11'h4f7;

    localparam logic [10:0] AGF_RST_PATTERN_LOW = 11'h000;
    localparam logic [10:0] AGF_RST_FINE_GAIN = 11'h000;
    localparam logic [10:0] AGF_RST_FORMAT = 11'h000;

    // field positions
    localparam int AGF_POS_PAT_HIGH = 0;
    localparam int AGF_POS_FINE_GAIN = 8;
    localparam int AGF_POS_TWO_WIRE = 0;
    localparam int AGF_POS_SDR = 1;
    localparam int AGF_POS_SER16 = 2;
    localparam int AGF_POS_CAPTURE_RISE = 4;
    localparam int AGF_POS_COARSE_GAIN = 5;
    localparam int AGF_POS_LSB_FIRST = 6;
    localparam int AGF_POS_BIT_WISE = 7;
    localparam int AGF_POS_OVERRIDE = 10;
    localparam int AGF_POS_SOFT_RESET = 10;

    localparam logic [2:0] AGF_FINE_GAIN_MAX = 3'h6;

endpackage

// file: agf_regs.sv
// gain and output format register bank with wishbone classic slave
// assumes one clock, synchronous reset, pins synchronous to clk_i
`timescale 1ns/1ps

module agf_regs
    import agf_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,

    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [6:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,

    // parallel control pins
    input wire logic pin_two_wire_i,
    input wire logic pin_sdr_i,
    input wire logic pin_ser16_i,
    input wire logic pin_capture_rise_i,
    input wire logic pin_coarse_gain_i,
    input wire logic pin_lsb_first_i,
    input wire logic pin_bit_wise_i,

    // effective settings toward the serializer and gain stage
    output logic two_wire_o,
    output logic sdr_clock_o,
    output logic ser16_o,
    output logic capture_rise_o,
    output logic coarse_gain_o,
    output logic lsb_first_o,
    output logic bit_wise_o,
    output logic [2:0] fine_gain_db_o,
    output logic [13:0] custom_pattern_o
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // byte-lane masked write restricted to the implemented bits
    function automatic logic [10:0] merge_write(
        input logic [10:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0] sel,
        input logic [10:0] mask
    );
        logic [10:0] lanes;
        lanes = {{3{sel[1]}}, {8{sel[0]}}} & mask;
        merge_write = (old_val & ~lanes) | (wdata[10:0] & lanes);
    endfunction

    // undefined code 111 is held at the top step rather than wrapping
    function automatic logic [2:0] decode_fine_gain(
        input logic [2:0] code
    );
        if (code > AGF_FINE_GAIN_MAX) begin
            decode_fine_gain = AGF_FINE_GAIN_MAX;
        end else begin
            decode_fine_gain = code;
        end
    endfunction

    // pick the register bit over the pin only while override is set
    function automatic logic pick(
        input logic ovr,
        input logic reg_bit,
        input logic pin_bit
    );
        pick = ovr ? reg_bit : pin_bit;
    endfunction

    // a register answers only at its word address; off-grid bytes hit nothing
    function automatic logic hits(
        input logic ok,
        input logic [4:0] index_now,
        input logic [4:0] idx
    );
        hits = ok && (index_now == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // storage

    logic [10:0] pattern_low;
    logic [10:0] fine_gain_and_pattern_high;
    logic [10:0] output_format_control;
    logic soft_reset;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic [4:0] index;
    logic word_ok;
    logic req;
    logic commit;
    logic hit_soft;
    logic hit_low;
    logic hit_fine;
    logic hit_format;
    logic hit_status;
    logic mapped;

    assign index = adr_i[6:2];
    // a byte address off the word grid is treated as unmapped
    assign word_ok = (adr_i[1:0] == 2'h0);
    assign req = cyc_i && stb_i;
    // a write takes effect on the edge at which the master sees ack
    assign commit = req && we_i && ack_o;

    assign hit_soft = hits(word_ok, index, AGF_IDX_SOFT_RESET);
    assign hit_low = hits(word_ok, index, AGF_IDX_PATTERN_LOW);
    assign hit_fine = hits(word_ok, index, AGF_IDX_FINE_GAIN);
    assign hit_format = hits(word_ok, index, AGF_IDX_FORMAT);
    assign hit_status = hits(word_ok, index, AGF_IDX_STATUS);
    assign mapped = hit_soft || hit_low || hit_fine || hit_format || hit_status;

    ////////////////////////////////////////////////////////////////////////////
    // acknowledge

    // ack drops in the cycle after it was given, so every access costs
    // one wait state; unmapped addresses are still acknowledged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else if (ce_i) begin
            ack_o <= req && !ack_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software reset strobe

    // self-clearing: the clear of the bank follows one cycle after the write
    // so the acknowledging write itself still completes undisturbed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_reset <= 1'b0;
        end else if (ce_i) begin
            soft_reset <= commit && hit_soft && sel_i[1] && dat_i[AGF_POS_SOFT_RESET];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register 0b

    // the soft reset strobe outranks a write landing in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pattern_low <= AGF_RST_PATTERN_LOW;
        end else if (ce_i) begin
            if (soft_reset) begin
                pattern_low <= AGF_RST_PATTERN_LOW;
            end else if (commit && hit_low) begin
                pattern_low <= merge_write(pattern_low, dat_i, sel_i,
                    AGF_MASK_PATTERN_LOW);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register 0c

    // fixed-zero bits 7..3 are never stored, whatever the host writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fine_gain_and_pattern_high <= AGF_RST_FINE_GAIN;
        end else if (ce_i) begin
            if (soft_reset) begin
                fine_gain_and_pattern_high <= AGF_RST_FINE_GAIN;
            end else if (commit && hit_fine) begin
                fine_gain_and_pattern_high <= merge_write(
                    fine_gain_and_pattern_high, dat_i, sel_i,
                    AGF_MASK_FINE_GAIN);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register 0d

    // fixed-zero bits 9, 8 and 3 are dropped the same way as in 0c
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_format_control <= AGF_RST_FORMAT;
        end else if (ce_i) begin
            if (soft_reset) begin
                output_format_control <= AGF_RST_FORMAT;
            end else if (commit && hit_format) begin
                output_format_control <= merge_write(
                    output_format_control, dat_i, sel_i,
                    AGF_MASK_FORMAT);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // resolve register against pins

    logic ovr;
    logic sel_two_wire;
    logic sel_sdr;
    logic sel_ser16;
    logic sel_capture_rise;
    logic sel_coarse_gain;
    logic sel_lsb_first;
    logic sel_bit_wise;
    logic sdr_active;

    // override steers only the format bits; fine gain and pattern have no pins
    assign ovr = output_format_control[AGF_POS_OVERRIDE];

    assign sel_two_wire = pick(ovr, output_format_control[AGF_POS_TWO_WIRE],
        pin_two_wire_i);
    assign sel_sdr = pick(ovr, output_format_control[AGF_POS_SDR],
        pin_sdr_i);
    assign sel_ser16 = pick(ovr, output_format_control[AGF_POS_SER16],
        pin_ser16_i);
    assign sel_capture_rise = pick(ovr,
        output_format_control[AGF_POS_CAPTURE_RISE], pin_capture_rise_i);
    assign sel_coarse_gain = pick(ovr,
        output_format_control[AGF_POS_COARSE_GAIN], pin_coarse_gain_i);
    assign sel_lsb_first = pick(ovr,
        output_format_control[AGF_POS_LSB_FIRST], pin_lsb_first_i);
    assign sel_bit_wise = pick(ovr, output_format_control[AGF_POS_BIT_WISE],
        pin_bit_wise_i);
    // the sdr clock choice only exists while two lanes are in use
    assign sdr_active = sel_two_wire && sel_sdr;

    ////////////////////////////////////////////////////////////////////////////
    // effective serializer format

    // bits that only mean something in a given mode are forced to their
    // zero meaning outside it, so the serializer never sees a stale choice
    // lane count and lane split
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            two_wire_o <= 1'b0;
            bit_wise_o <= 1'b0;
        end else if (ce_i) begin
            two_wire_o <= sel_two_wire;
            bit_wise_o <= sel_two_wire && sel_bit_wise;
        end
    end

    // bit clock kind and capture edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdr_clock_o <= 1'b0;
            capture_rise_o <= 1'b0;
        end else if (ce_i) begin
            sdr_clock_o <= sdr_active;
            capture_rise_o <= sdr_active && sel_capture_rise;
        end
    end

    // word length and bit order
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ser16_o <= 1'b0;
            lsb_first_o <= 1'b0;
        end else if (ce_i) begin
            ser16_o <= sel_ser16;
            lsb_first_o <= sel_lsb_first;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gain and test pattern

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coarse_gain_o <= 1'b0;
            fine_gain_db_o <= 3'h0;
        end else if (ce_i) begin
            coarse_gain_o <= sel_coarse_gain;
            fine_gain_db_o <= decode_fine_gain(
                fine_gain_and_pattern_high[AGF_POS_FINE_GAIN +: 3]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            custom_pattern_o <= 14'h0000;
        end else if (ce_i) begin
            custom_pattern_o <= {
                fine_gain_and_pattern_high[AGF_POS_PAT_HIGH +: 3],
                pattern_low};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data

    logic [31:0] next_dat;
    logic [10:0] status_word;

    // status shows what the serializer is actually running with
    always_comb begin
        status_word = 11'h000;
        status_word[AGF_POS_TWO_WIRE] = two_wire_o;
        status_word[AGF_POS_SDR] = sdr_clock_o;
        status_word[AGF_POS_SER16] = ser16_o;
        status_word[AGF_POS_CAPTURE_RISE] = capture_rise_o;
        status_word[AGF_POS_COARSE_GAIN] = coarse_gain_o;
        status_word[AGF_POS_LSB_FIRST] = lsb_first_o;
        status_word[AGF_POS_BIT_WISE] = bit_wise_o;
        status_word[AGF_POS_OVERRIDE] = ovr;
    end

    always_comb begin
        next_dat = 32'h0000_0000;
        if (hit_low) begin
            next_dat[10:0] = pattern_low;
        end else if (hit_fine) begin
            next_dat[10:0] = fine_gain_and_pattern_high;
        end else if (hit_format) begin
            next_dat[10:0] = output_format_control;
        end else if (hit_status) begin
            next_dat[10:0] = status_word;
        end else if (!mapped) begin
            next_dat = 32'h0000_0000;
        end
    end

    // data is loaded with ack on reads only and held until the next read is acknowledged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            if (req && !ack_o && !we_i) begin
                dat_o <= next_dat;
            end
        end
    end

endmodule

// file: agf_host.sv
// host controller model for the gain and output format register bank
// assumes a wishbone classic slave; a hung wait is cut by the bench watchdog
`timescale 1ns/1ps

module agf_host (
    // clock
    input wire logic clk_i,
    // wishbone master
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [6:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 7'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    ////////////////////////////////////////
    // one classic cycle; read data is taken at the ack edge only
    task automatic access(input logic w, input logic [6:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        {cyc_o, stb_o, we_o} <= 3'b000;
        // released data lines must not keep showing the old value
        dat_o <= ~d;
    endtask
endmodule

// file: agf_regs_checker.sv
// concurrent checks on the gain and output format register bank
// assumes it is bound to agf_regs and sees only its ports
`timescale 1ns/1ps

module agf_regs_checker (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave side
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [6:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // parallel control pins
    input wire logic pin_two_wire_i,
    input wire logic pin_sdr_i,
    input wire logic pin_ser16_i,
    input wire logic pin_capture_rise_i,
    input wire logic pin_coarse_gain_i,
    input wire logic pin_lsb_first_i,
    input wire logic pin_bit_wise_i,
    // effective settings
    input wire logic two_wire_o,
    input wire logic sdr_clock_o,
    input wire logic ser16_o,
    input wire logic capture_rise_o,
    input wire logic coarse_gain_o,
    input wire logic lsb_first_o,
    input wire logic bit_wise_o,
    input wire logic [2:0] fine_gain_db_o,
    input wire logic [13:0] custom_pattern_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////
    ack_answer_a: assert property (ce_i && cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged next cycle");
    ack_pulse_a: assert property (ce_i && ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    read_hold_a: assert property (ce_i && !(cyc_i && stb_i && !we_i && !ack_o) |=> $stable(dat_o))
        else $error("read data changed without a read");
    // reset itself is the antecedent here, so it cannot disable the check
    reset_clear_a: assert property (disable iff (1'b0) rst_i && ce_i |=> !ack_o
        && custom_pattern_o == 14'h0000 && fine_gain_db_o == 3'h0 && !two_wire_o
        && !ser16_o && !coarse_gain_o && !lsb_first_o) else $error("reset left a setting");
    sdr_mode_a: assert property (sdr_clock_o |-> two_wire_o)
        else $error("sdr clock outside 2-wire mode");
    capture_mode_a: assert property (capture_rise_o |-> sdr_clock_o)
        else $error("capture edge set outside sdr mode");
    split_mode_a: assert property (bit_wise_o |-> two_wire_o)
        else $error("bit-wise split outside 2-wire mode");
    gain_range_a: assert property (fine_gain_db_o <= 3'h6)
        else $error("fine gain above 6 dB");
endmodule

// file: agf_regs_tb_top.sv
// self-checking bench for the gain and output format register bank
// assumes agf_regs, its checker and the host model are compiled first
`timescale 1ns/1ps

module agf_regs_tb_top;
    import agf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack;
    logic [6:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, got;
    logic [6:0] pins = 7'h00;
    wire [6:0] outs;
    logic [2:0] gain;
    logic [13:0] pat;
    int bad_count = 0;
    int checked = 0;
    // format writes and expected effective settings {bit_wise .. two_wire}
    logic [10:0] fmt [6] = '{11'h4f7, 11'h4f6, 11'h4f5, 11'h4b3, 11'h441, 11'h0b3};
    logic [6:0] exp_v [6] = '{7'h7f, 7'h34, 7'h75, 7'h5b, 7'h21, 7'h34};

    always #10 clk_i = ~clk_i;

    agf_host i_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    // clock enable tied high: freezing is not a documented behaviour
    agf_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .pin_two_wire_i(pins[0]), .pin_sdr_i(pins[1]), .pin_ser16_i(pins[2]),
        .pin_capture_rise_i(pins[3]), .pin_coarse_gain_i(pins[4]),
        .pin_lsb_first_i(pins[5]), .pin_bit_wise_i(pins[6]),
        .two_wire_o(outs[0]), .sdr_clock_o(outs[1]), .ser16_o(outs[2]),
        .capture_rise_o(outs[3]), .coarse_gain_o(outs[4]), .lsb_first_o(outs[5]),
        .bit_wise_o(outs[6]), .fine_gain_db_o(gain), .custom_pattern_o(pat));

    ////////////////////////////////////////
    task automatic wr(input logic [6:0] a, input logic [10:0] d);
        i_host.access(1'b1, a, {21'h0, d}, 4'h3, got);
    endtask

    task automatic chk_rd(input logic [6:0] a, input logic [31:0] exp);
        i_host.access(1'b0, a, 32'h0, 4'h3, got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t read %h expected %h", $time, got, exp);
        end
    endtask

    // settings lag their source by one clock; two edges leave margin for pins
    task automatic chk_set(input logic [6:0] o, input logic [2:0] g, input logic [13:0] p);
        repeat (2) @(posedge clk_i);
        #1;
        checked++;
        if ({outs, gain, pat} !== {o, g, p}) begin
            bad_count++;
            $display("BAD %0t settings %h expected %h", $time, {outs, gain, pat}, {o, g, p});
        end
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_set(7'h00, 3'h0, 14'h0000);
        chk_rd(7'h30, 32'h0);
        chk_rd(7'h34, 32'h0);
        wr(7'h2c, 11'h6a5);
        for (int i = 0; i < 7; i++) begin
            wr(7'h30, {i[2:0], 5'h00, 3'h5});
            chk_set(7'h00, i[2:0], {3'h5, 11'h6a5});
        end
        chk_rd(7'h30, 32'h605);
        chk_rd(7'h2c, 32'h6a5);
        @(posedge clk_i);
        pins <= 7'h7e;
        for (int i = 0; i < 6; i++) begin
            wr(7'h34, fmt[i]);
            chk_set(exp_v[i], 3'h6, {3'h5, 11'h6a5});
        end
        @(posedge clk_i);
        pins <= 7'h2b;
        chk_set(7'h2b, 3'h6, {3'h5, 11'h6a5});
        chk_rd(7'h78, 32'h053);
        wr(7'h40, 11'h7ff);
        chk_rd(7'h40, 32'h0);
        chk_rd(7'h34, 32'h0b3);
        i_host.access(1'b1, 7'h00, 32'h400, 4'h2, got);
        chk_rd(7'h2c, 32'h0);
        chk_rd(7'h30, 32'h0);
        chk_rd(7'h34, 32'h0);
        chk_set(7'h2b, 3'h0, 14'h0000);
        give_verdict();
    end

    // the whole sequence needs about 115 cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        bad_count++;
        give_verdict();
    end
endmodule

bind agf_regs agf_regs_checker i_chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .pin_two_wire_i, .pin_sdr_i, .pin_ser16_i,
    .pin_capture_rise_i, .pin_coarse_gain_i, .pin_lsb_first_i, .pin_bit_wise_i,
    .two_wire_o, .sdr_clock_o, .ser16_o, .capture_rise_o, .coarse_gain_o, .lsb_first_o,
    .bit_wise_o, .fine_gain_db_o, .custom_pattern_o);
